// File: logic/sdg_converter_ctrl.sv
// converter control: register file, clock divider, decimating filter and front-end settings
// Operation
// - amp_ctrl_one bit 7 picks common-mode level 1.05V or 1.25V; resets to 1
// - amp_ctrl_one bit 6 input-end connect, bits 3..1 offset trim, read/write, reset zero
// - output rate equals converter clock over filter constant times oversample factor
// - filter code 000 gives divide-by-30; oversample code 000 gives chopper 2, OSR 8192
// - a 3.2kHz output rate is available for automatic power-on
// - filter turns modulator bit stream into 20-bit results stored in result registers
// - result read-only: low bits 7..0, middle 15..8, high 19..16 in bits 3..0
// - ten registers: three result registers and seven control registers
// - two differential channels, each may pass the gain amplifier
// - channel select holds positive selector bits 2..0, negative selector bits 5..3
// - reference gain bits 6..5: 00 is 1, 01 is 1/2, 10 is 1/4, 11 reserved
// - converter gain bits 4..3: 1, 2, 4 or 8
// - amplifier gain bits 2..0 map binary powers; register resets to zero
// - control-zero holds reset, sleep, power-off, oversample field and reference select
// - control-one holds filter mode, buffer enables, latch, end flag; clock-select divider
// - unimplemented bits of gain and common-mode registers read zero
// - common-mode output active only if powered, regulator enabled and common-mode enabled
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module sdg_converter_ctrl
  import sdg_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // modulator side
  input wire logic modulator_bit,
  output logic converter_clock_tick,
  output sdg_afe_ctrl_t afe_ctrl
);

  function automatic logic [7:0] reg_mask(input logic [7:0] ofs);
    unique case (ofs)
      OFS_GAIN_CTRL_ZERO: reg_mask = MSK_GAIN_CTRL_ZERO;
      OFS_AMP_CTRL_ONE: reg_mask = MSK_AMP_CTRL_ONE;
      OFS_INPUT_CHANNEL_SELECT: reg_mask = MSK_INPUT_CHANNEL_SELECT;
      OFS_CONVERTER_CTRL_ZERO: reg_mask = MSK_CONVERTER_CTRL_ZERO;
      OFS_CONVERTER_CTRL_ONE: reg_mask = MSK_CONVERTER_CTRL_ONE;
      OFS_CONVERTER_CLOCK_SELECT: reg_mask = MSK_CONVERTER_CLOCK_SELECT;
      OFS_POWER_CTRL: reg_mask = MSK_POWER_CTRL;
      default: reg_mask = 8'h00;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] ofs);
    is_mapped = (reg_mask(ofs) != 8'h00) || ofs == OFS_RESULT_LOW || ofs == OFS_RESULT_MIDDLE ||
      ofs == OFS_RESULT_HIGH;
  endfunction

  // control registers
  logic [7:0] gain_ctrl_zero_r;
  logic [7:0] amp_ctrl_one_r;
  logic [7:0] input_channel_select_r;
  logic [7:0] converter_ctrl_zero_r;
  logic [7:0] converter_ctrl_one_r;
  logic [7:0] converter_clock_select_r;
  logic [7:0] power_ctrl_r;
  logic [RESULT_W-1:0] result_r;

  // write channel
  logic aw_held_r;
  logic [7:0] aw_addr_r;
  logic w_held_r;
  logic [7:0] w_data_r;
  logic w_lane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_held_r && w_held_r && !bvalid_r;
  wire [7:0] wr_mask = reg_mask(aw_addr_r);
  wire wr_en = wr_go && w_lane_r;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= is_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // filter handshake signals used by the register file
  logic result_done;
  wire eoc_clear = wr_en && aw_addr_r == OFS_CONVERTER_CTRL_ONE && !w_data_r[B_EOC];
  wire [7:0] ctrl_one_nxt = {(w_data_r & wr_mask & ~8'h02) | (converter_ctrl_one_r & ~wr_mask) |
    (converter_ctrl_one_r & 8'h02)};

  function automatic logic [7:0] merged(input logic [7:0] cur, input logic [7:0] dat, input logic [7:0] msk);
    merged = (dat & msk) | (cur & ~msk);
  endfunction

  always_ff @(posedge clock) begin
    if (!rstn) begin
      gain_ctrl_zero_r <= RST_GAIN_CTRL_ZERO;
      amp_ctrl_one_r <= RST_AMP_CTRL_ONE;
      input_channel_select_r <= RST_INPUT_CHANNEL_SELECT;
      converter_ctrl_zero_r <= RST_CONVERTER_CTRL_ZERO;
      converter_ctrl_one_r <= RST_CONVERTER_CTRL_ONE;
      converter_clock_select_r <= RST_CONVERTER_CLOCK_SELECT;
      power_ctrl_r <= RST_POWER_CTRL;
    end else begin
      // masks keep unimplemented bits at zero
      if (wr_en && aw_addr_r == OFS_GAIN_CTRL_ZERO)
        gain_ctrl_zero_r <= merged(gain_ctrl_zero_r, w_data_r, wr_mask);
      if (wr_en && aw_addr_r == OFS_AMP_CTRL_ONE)
        amp_ctrl_one_r <= merged(amp_ctrl_one_r, w_data_r, wr_mask);
      if (wr_en && aw_addr_r == OFS_INPUT_CHANNEL_SELECT)
        input_channel_select_r <= merged(input_channel_select_r, w_data_r, wr_mask);
      if (wr_en && aw_addr_r == OFS_CONVERTER_CTRL_ZERO)
        converter_ctrl_zero_r <= merged(converter_ctrl_zero_r, w_data_r, wr_mask);
      if (wr_en && aw_addr_r == OFS_CONVERTER_CLOCK_SELECT)
        converter_clock_select_r <= merged(converter_clock_select_r, w_data_r, wr_mask);
      if (wr_en && aw_addr_r == OFS_POWER_CTRL)
        power_ctrl_r <= merged(power_ctrl_r, w_data_r, wr_mask);
      // end flag: software clears by writing zero, a completing result wins
      if (wr_en && aw_addr_r == OFS_CONVERTER_CTRL_ONE)
        converter_ctrl_one_r <= ctrl_one_nxt;
      if (result_done)
        converter_ctrl_one_r[B_EOC] <= 1'b1;
      else if (eoc_clear)
        converter_ctrl_one_r[B_EOC] <= 1'b0;
    end
  end

  // read channel
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] rd_val;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_comb begin
    unique case (s_axi_araddr)
      OFS_GAIN_CTRL_ZERO: rd_val = gain_ctrl_zero_r;
      OFS_AMP_CTRL_ONE: rd_val = amp_ctrl_one_r;
      OFS_INPUT_CHANNEL_SELECT: rd_val = input_channel_select_r;
      OFS_RESULT_LOW: rd_val = result_r[7:0];
      OFS_RESULT_MIDDLE: rd_val = result_r[15:8];
      OFS_RESULT_HIGH: rd_val = {4'h0, result_r[19:16]};
      OFS_CONVERTER_CTRL_ZERO: rd_val = converter_ctrl_zero_r;
      OFS_CONVERTER_CTRL_ONE: rd_val = converter_ctrl_one_r;
      OFS_CONVERTER_CLOCK_SELECT: rd_val = converter_clock_select_r;
      OFS_POWER_CTRL: rd_val = power_ctrl_r;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_val};
      rresp_r <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // field views
  wire conv_reset = converter_ctrl_zero_r[B_CONV_RESET];
  wire conv_sleep = converter_ctrl_zero_r[B_CONV_SLEEP];
  wire conv_power_off = converter_ctrl_zero_r[B_CONV_POWER_OFF];
  wire [2:0] osr_code = converter_ctrl_zero_r[B_OSR_LO+:3];
  wire [2:0] filt_code = converter_ctrl_one_r[B_FILTER_LO+:3];
  wire latch_hold = converter_ctrl_one_r[B_LATCH];
  wire [4:0] clk_div = converter_clock_select_r[B_CLK_DIV_LO+:5];
  wire [2:0] amp_code = gain_ctrl_zero_r[B_AMP_GAIN_LO+:3];
  wire [1:0] conv_code = gain_ctrl_zero_r[B_CONV_GAIN_LO+:2];
  wire [1:0] ref_code = gain_ctrl_zero_r[B_REF_GAIN_LO+:2];
  wire cm_cond = !conv_power_off && power_ctrl_r[B_REGULATOR] && power_ctrl_r[B_CM_ENABLE];

  // front-end settings, registered so the analog side sees clean levels
  sdg_afe_ctrl_t afe_nxt;
  always_comb begin
    afe_nxt.common_mode_level_sel = amp_ctrl_one_r[B_CM_LEVEL];
    afe_nxt.common_mode_active = cm_cond;
    afe_nxt.regulator_enable = power_ctrl_r[B_REGULATOR];
    afe_nxt.input_end_connect = amp_ctrl_one_r[B_INPUT_END];
    afe_nxt.input_offset_trim = amp_ctrl_one_r[B_OFFSET_LO+:3];
    // reserved code falls back to unity so a bad write never overdrives
    afe_nxt.reference_gain_shift = (ref_code == 2'h3) ? 2'h0 : ref_code;
    afe_nxt.converter_gain_mult = 4'h1 << conv_code;
    afe_nxt.amplifier_gain_mult = 8'h01 << amp_code;
    afe_nxt.positive_input_sel = input_channel_select_r[B_POS_SEL_LO+:3];
    afe_nxt.negative_input_sel = input_channel_select_r[B_NEG_SEL_LO+:3];
    afe_nxt.reference_source_sel = converter_ctrl_zero_r[B_REF_SOURCE];
    afe_nxt.pos_reference_buffer_en = converter_ctrl_one_r[B_POS_BUF];
    afe_nxt.neg_reference_buffer_en = converter_ctrl_one_r[B_NEG_BUF];
    afe_nxt.converter_sleep = conv_sleep;
    afe_nxt.converter_power_off = conv_power_off;
  end

  always_ff @(posedge clock) begin
    if (!rstn)
      afe_ctrl <= '0;
    else
      afe_ctrl <= afe_nxt;
  end

  // converter clock: one tick every clk_div+1 master cycles
  logic [4:0] div_cnt_r;
  logic tick_r;
  wire div_hit = div_cnt_r >= clk_div;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      div_cnt_r <= 5'h00;
      tick_r <= 1'b0;
    end else begin
      div_cnt_r <= div_hit ? 5'h00 : div_cnt_r + 5'h01;
      tick_r <= div_hit;
    end
  end
  assign converter_clock_tick = tick_r;

  // modulator stream arrives from the analog domain
  logic mod_meta_r;
  logic mod_sync_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mod_meta_r <= 1'b0;
      mod_sync_r <= 1'b0;
    end else begin
      mod_meta_r <= modulator_bit;
      mod_sync_r <= mod_meta_r;
    end
  end

  // decimation length = filter constant x oversample factor
  wire [4:0] filt_const = (filt_code == FILT_CODE_NORMAL) ? FILT_NORMAL : FILT_FAST;
  wire [19:0] osr_factor = (osr_code == OSR_CODE_AUTO) ? AUTO_FACTOR : (OSR_BASE << osr_code);
  wire [24:0] win_len = 25'(filt_const * osr_factor);

  sdg_filt_state_t state_r;
  sdg_filt_state_t state_nxt;
  logic [24:0] win_cnt_r;
  logic signed [25:0] acc_r;
  wire filt_stop = conv_reset || conv_sleep || conv_power_off;
  wire win_end = tick_r && (win_cnt_r >= win_len - 25'd1);
  wire signed [25:0] acc_step = mod_sync_r ? 26'sd1 : -26'sd1;
  wire signed [25:0] res_max = 26'sh007_FFFF;
  wire signed [25:0] res_min = -26'sh008_0000;
  wire [19:0] res_sat = (acc_r > res_max) ? 20'h7_FFFF : (acc_r < res_min) ? 20'h8_0000 : acc_r[19:0];

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF: state_nxt = filt_stop ? ST_OFF : ST_RUN;
      ST_RUN: state_nxt = filt_stop ? ST_OFF : (win_end ? ST_DONE : ST_RUN);
      ST_DONE: state_nxt = filt_stop ? ST_OFF : ST_RUN;
      default: state_nxt = ST_OFF;
    endcase
  end
  assign result_done = (state_r == ST_DONE);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r <= ST_OFF;
      win_cnt_r <= 25'd0;
      acc_r <= 26'sd0;
    end else begin
      state_r <= state_nxt;
      // the last tick of a window is summed; the done cycle keeps its tick so the rate stays exact
      if (state_r == ST_RUN && tick_r) begin
        win_cnt_r <= win_end ? 25'd0 : win_cnt_r + 25'd1;
        acc_r <= acc_r + acc_step;
      end else if (state_r == ST_DONE && tick_r) begin
        win_cnt_r <= 25'd1;
        acc_r <= acc_step;
      end else if (state_r != ST_RUN) begin
        win_cnt_r <= 25'd0;
        acc_r <= 26'sd0;
      end
    end
  end

  // result only changes from the filter; bus writes never reach it
  always_ff @(posedge clock) begin
    if (!rstn)
      result_r <= 20'h0_0000;
    else if (result_done && !latch_hold)
      result_r <= res_sat;
  end

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_cm_output_gate: assert property (##1 afe_ctrl.common_mode_active == $past(cm_cond))
    else $error("common-mode output does not follow its enables");
  // the front-end copy is cleared for one cycle after reset, so skip that cycle
  a_amp_gain_map: assert property ($past(rstn) |->
    afe_ctrl.amplifier_gain_mult == (8'h01 << $past(amp_code)))
    else $error("amplifier gain multiplier wrong");
  a_cm_level_map: assert property ($past(rstn) |->
    afe_ctrl.common_mode_level_sel == $past(amp_ctrl_one_r[7]))
    else $error("common-mode level not from bit 7");
  a_result_read_only: assert property (!(result_done && !latch_hold) |=> $stable(result_r))
    else $error("result changed without a finished window");
  a_eoc_set_done: assert property (result_done |=> converter_ctrl_one_r[B_EOC])
    else $error("end flag not set after a result");
  a_high_upper_zero: assert property (rvalid_r && rdata_r[7:0] != 8'h00 |-> rdata_r[31:8] == 24'h00_0000)
    else $error("read data above byte not zero");
  a_stop_halts_filter: assert property (filt_stop |=> state_r == ST_OFF ##1 !result_done)
    else $error("filter runs while stopped");
  a_write_resp_time: assert property (wr_go |=> s_axi_bvalid)
    else $error("write response late");
  a_gain_unimpl_zero: assert property (gain_ctrl_zero_r[7] == 1'b0 && amp_ctrl_one_r[5:4] == 2'h0 &&
    amp_ctrl_one_r[0] == 1'b0)
    else $error("unimplemented bit set");
  a_end_flag_sticky: assert property (converter_ctrl_one_r[B_EOC] && !eoc_clear |=> converter_ctrl_one_r[B_EOC])
    else $error("end flag dropped without a clear");
  a_unmapped_read_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |->
    s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  c_result_done: cover property (result_done);
  c_eoc_clear_race: cover property (result_done && eoc_clear);
  c_write_then_read: cover property (wr_go ##[1:10] (s_axi_arvalid && !rvalid_r));
  c_unmapped_write: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);

endmodule

// File: logic/sdg_pkg.sv
// package: register map, field positions, reset values, timing and carrier types for the converter control block
package sdg_pkg;

  // register byte offsets on the control bus
  localparam logic [7:0] OFS_GAIN_CTRL_ZERO = 8'h00;
  localparam logic [7:0] OFS_AMP_CTRL_ONE = 8'h04;
  localparam logic [7:0] OFS_INPUT_CHANNEL_SELECT = 8'h08;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h0C;
  localparam logic [7:0] OFS_RESULT_MIDDLE = 8'h10;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h14;
  localparam logic [7:0] OFS_CONVERTER_CTRL_ZERO = 8'h18;
  localparam logic [7:0] OFS_CONVERTER_CTRL_ONE = 8'h1C;
  localparam logic [7:0] OFS_CONVERTER_CLOCK_SELECT = 8'h20;
  localparam logic [7:0] OFS_POWER_CTRL = 8'h24;

  // reset values
  localparam logic [7:0] RST_GAIN_CTRL_ZERO = 8'h00;
  localparam logic [7:0] RST_AMP_CTRL_ONE = 8'h80;
  localparam logic [7:0] RST_INPUT_CHANNEL_SELECT = 8'h00;
  localparam logic [7:0] RST_CONVERTER_CTRL_ZERO = 8'h00;
  localparam logic [7:0] RST_CONVERTER_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_CONVERTER_CLOCK_SELECT = 8'h00;
  localparam logic [7:0] RST_POWER_CTRL = 8'h00;

  // writable masks; unimplemented bits read zero
  localparam logic [7:0] MSK_GAIN_CTRL_ZERO = 8'h7F;
  localparam logic [7:0] MSK_AMP_CTRL_ONE = 8'hCE;
  localparam logic [7:0] MSK_INPUT_CHANNEL_SELECT = 8'h3F;
  localparam logic [7:0] MSK_CONVERTER_CTRL_ZERO = 8'hFD;
  localparam logic [7:0] MSK_CONVERTER_CTRL_ONE = 8'hFE;
  localparam logic [7:0] MSK_CONVERTER_CLOCK_SELECT = 8'h1F;
  localparam logic [7:0] MSK_POWER_CTRL = 8'hC0;

  // field positions
  localparam int B_CM_LEVEL = 7;
  localparam int B_INPUT_END = 6;
  localparam int B_OFFSET_LO = 1;
  localparam int B_REF_GAIN_LO = 5;
  localparam int B_CONV_GAIN_LO = 3;
  localparam int B_AMP_GAIN_LO = 0;
  localparam int B_POS_SEL_LO = 0;
  localparam int B_NEG_SEL_LO = 3;
  localparam int B_CONV_RESET = 7;
  localparam int B_CONV_SLEEP = 6;
  localparam int B_CONV_POWER_OFF = 5;
  localparam int B_OSR_LO = 2;
  localparam int B_REF_SOURCE = 0;
  localparam int B_FILTER_LO = 5;
  localparam int B_NEG_BUF = 4;
  localparam int B_POS_BUF = 3;
  localparam int B_LATCH = 2;
  localparam int B_EOC = 1;
  localparam int B_CLK_DIV_LO = 0;
  localparam int B_REGULATOR = 7;
  localparam int B_CM_ENABLE = 6;
  localparam int RESULT_W = 20;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // decimation constants
  localparam logic [4:0] FILT_NORMAL = 5'h1E;
  localparam logic [4:0] FILT_FAST = 5'h0C;
  localparam logic [2:0] FILT_CODE_NORMAL = 3'h0;
  localparam logic [19:0] OSR_BASE = 20'h0_2000;
  localparam logic [2:0] OSR_CODE_AUTO = 3'h7;
  localparam int CONV_CLK_REF_HZ = 4800000;
  localparam int RATE_AUTO_HZ = 3200;
  localparam logic [19:0] AUTO_FACTOR = 20'(CONV_CLK_REF_HZ / (12 * RATE_AUTO_HZ));

  // settings carried to the analog front end
  typedef struct packed {
    logic common_mode_level_sel;
    logic common_mode_active;
    logic regulator_enable;
    logic input_end_connect;
    logic [2:0] input_offset_trim;
    logic [1:0] reference_gain_shift;
    logic [3:0] converter_gain_mult;
    logic [7:0] amplifier_gain_mult;
    logic [2:0] positive_input_sel;
    logic [2:0] negative_input_sel;
    logic reference_source_sel;
    logic pos_reference_buffer_en;
    logic neg_reference_buffer_en;
    logic converter_sleep;
    logic converter_power_off;
  } sdg_afe_ctrl_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } sdg_filt_state_t;

endpackage

// File: tb/sdg_converter_ctrl_test.sv
// testbench for the converter control block
`timescale 1ns/1ps
module sdg_converter_ctrl_test import sdg_pkg::*; ;
  logic clock, rstn, awv, wv, bre, arv, rre, mbit, awr, wrd, bv, arr, rv, tick;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic [1:0] br, rr, mode;
  sdg_afe_ctrl_t afe;
  int miscompares, cmp_count;
  sdg_converter_ctrl dut (.clock(clock), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .modulator_bit(mbit), .converter_clock_tick(tick), .afe_ctrl(afe));
  sdg_modulator_model model (.clock(clock), .mode(mode), .modulator_bit(mbit));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task end_sim;
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // ready is sampled on the falling edge, where it already shows the value of the next rising edge
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    // one edge of gap so a back-to-back call never re-raises a strobe in the step that dropped it
    @(posedge clock);
    awa <= a;
    wd <= {24'h0000_00, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clock);
      ta = awv & awr;
      tw = wv & wrd;
      tb = bv;
      @(posedge clock);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    bre <= 1'b0;
    chk("bresp", er, br);
  endtask
  task rc(input string n, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    @(posedge clock);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clock);
      ta = arv & arr;
      tr = rv;
      @(posedge clock);
      if (ta) arv <= 1'b0;
    end
    rre <= 1'b0;
    chk(n, e, rd);
    chk("rresp", er, rr);
  endtask
  task t_reset;
    rc("amp1", OFS_AMP_CTRL_ONE, 32'h0000_0080, RESP_OKAY);
    rc("gain0", OFS_GAIN_CTRL_ZERO, 32'h0000_0000, RESP_OKAY);
    chk("cm_level", 1, afe.common_mode_level_sel);
  endtask
  task t_masks;
    logic [7:0] ad [5];
    logic [7:0] ex [5];
    ad = '{OFS_GAIN_CTRL_ZERO, OFS_AMP_CTRL_ONE, OFS_INPUT_CHANNEL_SELECT, OFS_CONVERTER_CLOCK_SELECT, OFS_POWER_CTRL};
    ex = '{8'h7F, 8'hCE, 8'h3F, 8'h1F, 8'hC0};
    wr(OFS_CONVERTER_CTRL_ZERO, 8'hFF, RESP_OKAY);
    rc("ctrl0", OFS_CONVERTER_CTRL_ZERO, 32'h0000_00FD, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      wr(ad[i], 8'hFF, RESP_OKAY);
      rc("mask", ad[i], {24'h0000_00, ex[i]}, RESP_OKAY);
    end
  endtask
  task t_gain;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(OFS_GAIN_CTRL_ZERO, {1'b0, c[1:0], c[1:0], c}, RESP_OKAY);
      repeat (2) @(posedge clock);
      chk("amp_gain", 32'd1 << c, afe.amplifier_gain_mult);
      chk("conv_gain", 32'd1 << c[1:0], afe.converter_gain_mult);
      chk("ref_gain", (c[1:0] == 2'd3) ? 0 : c[1:0], afe.reference_gain_shift);
    end
    wr(OFS_INPUT_CHANNEL_SELECT, 8'h2B, RESP_OKAY);
    repeat (2) @(posedge clock);
    chk("pos_sel", 3, afe.positive_input_sel);
    chk("neg_sel", 5, afe.negative_input_sel);
  endtask
  // converter is held in reset here, so the stored result cannot move under us
  task t_ro;
    wr(OFS_RESULT_LOW, 8'hA5, RESP_OKAY);
    rc("res_lo", OFS_RESULT_LOW, 32'h0000_0000, RESP_OKAY);
    ws <= 4'h0;
    wr(OFS_AMP_CTRL_ONE, 8'h00, RESP_OKAY);
    ws <= 4'h1;
    rc("no_strobe", OFS_AMP_CTRL_ONE, 32'h0000_00CE, RESP_OKAY);
    wr(8'h28, 8'h11, RESP_SLVERR);
    rc("unmapped", 8'h28, 32'h0000_0000, RESP_SLVERR);
  endtask
  // short window: filter code 001 gives 12, oversample code 111 gives 125
  task t_conv(input logic [1:0] m);
    logic [19:0] e;
    int n;
    e = m[0] ? 20'd1500 : -20'd1500;
    mode <= m;
    wr(OFS_CONVERTER_CTRL_ZERO, 8'h9C, RESP_OKAY);
    wr(OFS_CONVERTER_CLOCK_SELECT, 8'h00, RESP_OKAY);
    wr(OFS_CONVERTER_CTRL_ONE, 8'h20, RESP_OKAY);
    wr(OFS_CONVERTER_CTRL_ZERO, 8'h1C, RESP_OKAY);
    n = 0;
    while (rd[1] !== 1'b1 && n < 800) begin
      @(posedge clock);
      ara <= OFS_CONVERTER_CTRL_ONE;
      arv <= 1'b1;
      rre <= 1'b1;
      do @(posedge clock); while (!rv);
      arv <= 1'b0;
      rre <= 1'b0;
      n++;
    end
    chk("end_flag", 1, rd[1]);
    rc("res_lo", OFS_RESULT_LOW, {24'h0000_00, e[7:0]}, RESP_OKAY);
    rc("res_mid", OFS_RESULT_MIDDLE, {24'h0000_00, e[15:8]}, RESP_OKAY);
    rc("res_hi", OFS_RESULT_HIGH, {28'h0000_000, e[19:16]}, RESP_OKAY);
  endtask
  // divider 3 gives one tick every fourth clock
  task t_tick;
    int k;
    wr(OFS_CONVERTER_CLOCK_SELECT, 8'h03, RESP_OKAY);
    k = 0;
    repeat (16) begin
      @(posedge clock);
      k += tick;
    end
    chk("ticks", 4, k);
  endtask
  task t_cm;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(OFS_CONVERTER_CTRL_ZERO, {2'b00, c[2], 5'h00}, RESP_OKAY);
      wr(OFS_POWER_CTRL, {c[1:0], 6'h00}, RESP_OKAY);
      repeat (2) @(posedge clock);
      chk("cm_active", !c[2] && c[1] && c[0], afe.common_mode_active);
      chk("power_off", c[2], afe.converter_power_off);
    end
  endtask
  initial begin
    #(5 * 20000);
    miscompares++;
    end_sim;
  end
  initial begin
    {rstn, awv, wv, bre, arv, rre, awa, ara, wd} = '0;
    ws = 4'h1;
    mode = 2'd2;
    miscompares = 0;
    cmp_count = 0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_reset;
    t_masks;
    t_tick;
    t_gain;
    t_ro;
    t_conv(2'd1);
    t_conv(2'd0);
    t_cm;
    end_sim;
  end
endmodule

// File: tb/sdg_modulator_model.sv
// modulator stand-in driving the one-bit stream
`timescale 1ns/1ps
module sdg_modulator_model (
  // clock and pattern select
  input wire logic clock,
  input wire logic [1:0] mode,
  // stream
  output logic modulator_bit
);
  // mode 0 zeros, 1 ones, 2 toggles each clock so a stale level never looks settled
  initial modulator_bit = 1'b0;
  always @(posedge clock) modulator_bit <= mode[1] ? ~modulator_bit : mode[0];
endmodule
